/* core/dctm_top.v */
// Dual 13-bit counter/timer block with register port and interrupt.
`include "dctm_regs.vh"

module dctm_top (
	input  wire       sys_clk,
	input  wire       rstn,
	input  wire [7:0] regAddr,
	input  wire [7:0] regWdata,
	input  wire       regWrite,
	input  wire       regRead,
	output reg  [7:0] regRdata,
	input  wire       firstCountInputPin,
	input  wire       secondCountInputPin,
	input  wire       firstGateInput,
	input  wire       secondGateInput,
	output reg        firstTimerIrq,
	output reg        secondTimerIrq,
	output reg        irqOut
);

	reg  [7:0] ctrl_reg;
	reg  [7:0] ctrl_next;
	reg  [7:0] mode_reg;
	reg  [7:0] scale_reg;
	reg  [7:0] irqCfg_reg;
	reg  [7:0] irqEn_reg;
	reg  [1:0] status_reg;
	reg  [1:0] status_next;
	reg  [1:0] mask_reg;
	reg  [7:0] prescale_reg;
	reg  [7:0] divide;
	reg        scaleTick_reg;
	reg  [7:0] rdata_next;
	wire [7:0]  low0;
	wire [7:0]  low1;
	wire [7:0]  high0;
	wire [7:0]  high1;
	wire        ovf0;
	wire        ovf1;
	wire        wrCtrl;
	wire [15:0] lowBytes;
	wire [15:0] highBytes;
	wire [1:0]  ovfPulse;
	wire [1:0]  countPins;
	wire [1:0]  gatePins;
	wire [1:0]  lowWr;
	wire [1:0]  highWr;

	assign wrCtrl    = regWrite && (regAddr == `DCTM_ADDR_CTRL);
	assign countPins = {secondCountInputPin, firstCountInputPin};
	assign gatePins  = {secondGateInput, firstGateInput};
	assign lowWr     = {regWrite && (regAddr == `DCTM_ADDR_LOW1),
	                    regWrite && (regAddr == `DCTM_ADDR_LOW0)};
	assign highWr    = {regWrite && (regAddr == `DCTM_ADDR_HIGH1),
	                    regWrite && (regAddr == `DCTM_ADDR_HIGH0)};
	assign low0      = lowBytes[7:0];
	assign low1      = lowBytes[15:8];
	assign high0     = highBytes[7:0];
	assign high1     = highBytes[15:8];
	assign ovf0      = ovfPulse[0];
	assign ovf1      = ovfPulse[1];

	// Modes 1 to 3 store their bits but run the 13-bit count.
	// Channel 1 fields sit one nibble, two bits or one bit above channel 0.
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			dctm_channel chan_i (
				.sys_clk       (sys_clk),
				.rstn          (rstn),
				.countPin      (countPins[ch]),
				.gatePin       (gatePins[ch]),
				.gatePolarity  (irqCfg_reg[`DCTM_CFG_POL0 + 4 * ch]),
				.runBit        (ctrl_reg[`DCTM_CTRL_RUN0 + 2 * ch]),
				.gateBit       (mode_reg[`DCTM_MODE_GATE + 4 * ch]),
				.counterSelect (mode_reg[`DCTM_MODE_CT + 4 * ch]),
				.sysclkSelect  (scale_reg[`DCTM_SCALE_SYS0 + ch]),
				.scaleTick     (scaleTick_reg),
				.lowWrite      (lowWr[ch]),
				.highWrite     (highWr[ch]),
				.writeData     (regWdata),
				.lowByte       (lowBytes[8 * ch +: 8]),
				.highByte      (highBytes[8 * ch +: 8]),
				.overflowPulse (ovfPulse[ch])
			);
		end
	endgenerate

	always @* begin
		case (scale_reg[1:0])
			2'h0:    divide = `DCTM_DIV_12;
			2'h1:    divide = `DCTM_DIV_4;
			2'h2:    divide = `DCTM_DIV_48;
			default: divide = `DCTM_DIV_8;
		endcase
	end

	// Shared prescaler; a changed divider applies at once, wrapping on the next edge if the count is already at or past it.
	always @(posedge sys_clk) begin
		if (!rstn) begin
			prescale_reg  <= 8'h00;
			scaleTick_reg <= 1'b0;
		end else if (prescale_reg >= divide - 8'h01) begin
			prescale_reg  <= 8'h00;
			scaleTick_reg <= 1'b1;
		end else begin
			prescale_reg  <= prescale_reg + 8'h01;
			scaleTick_reg <= 1'b0;
		end
	end

	// Hardware setting of an overflow flag wins over a software write.
	always @* begin
		ctrl_next = wrCtrl ? regWdata : ctrl_reg;
		if (ovf0)
			ctrl_next[`DCTM_CTRL_OVF0] = 1'b1;
		if (ovf1)
			ctrl_next[`DCTM_CTRL_OVF1] = 1'b1;
	end

	always @* begin
		status_next = status_reg;
		if (regWrite && (regAddr == `DCTM_ADDR_STATUS))
			status_next = status_reg & ~regWdata[1:0];
		status_next = status_next | {ovf1, ovf0};
	end

	always @* begin
		case (regAddr)
			`DCTM_ADDR_CTRL:   rdata_next = ctrl_reg;
			`DCTM_ADDR_MODE:   rdata_next = mode_reg;
			`DCTM_ADDR_LOW0:   rdata_next = low0;
			`DCTM_ADDR_LOW1:   rdata_next = low1;
			`DCTM_ADDR_HIGH0:  rdata_next = high0;
			`DCTM_ADDR_HIGH1:  rdata_next = high1;
			`DCTM_ADDR_SCALE:  rdata_next = scale_reg;
			`DCTM_ADDR_IRQCFG: rdata_next = irqCfg_reg;
			`DCTM_ADDR_IRQEN:  rdata_next = irqEn_reg;
			`DCTM_ADDR_STATUS: rdata_next = {6'h00, status_reg};
			`DCTM_ADDR_MASK:   rdata_next = {6'h00, mask_reg};
			default:           rdata_next = 8'h00;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_reg       <= `DCTM_RESET_BYTE;
			mode_reg       <= `DCTM_RESET_BYTE;
			scale_reg      <= `DCTM_RESET_BYTE;
			irqCfg_reg     <= `DCTM_RESET_BYTE;
			irqEn_reg      <= `DCTM_RESET_BYTE;
			status_reg     <= 2'h0;
			mask_reg       <= 2'h0;
			regRdata       <= 8'h00;
			firstTimerIrq  <= 1'b0;
			secondTimerIrq <= 1'b0;
			irqOut         <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			status_reg <= status_next;
			if (regWrite && regAddr == `DCTM_ADDR_MODE)
				mode_reg <= regWdata;
			if (regWrite && regAddr == `DCTM_ADDR_SCALE)
				scale_reg <= regWdata;
			if (regWrite && regAddr == `DCTM_ADDR_IRQCFG)
				irqCfg_reg <= regWdata;
			if (regWrite && regAddr == `DCTM_ADDR_IRQEN)
				irqEn_reg <= regWdata;
			if (regWrite && regAddr == `DCTM_ADDR_MASK)
				mask_reg <= regWdata[1:0];
			regRdata <= regRead ? rdata_next : 8'h00;
			firstTimerIrq  <= ctrl_next[`DCTM_CTRL_OVF0] &
			                  irqEn_reg[`DCTM_EN_IRQ0];
			secondTimerIrq <= ctrl_next[`DCTM_CTRL_OVF1] &
			                  irqEn_reg[`DCTM_EN_IRQ1];
			irqOut <= |(status_next & mask_reg);
		end
	end

endmodule

/* core/dctm_regs.vh */
// Register map, field positions and timing counts of the dual counter/timer.
// How it works
// - Each timer count is two byte registers.
// - Per-timer mode bit pair, independent configuration.
// - Mode 0: 13-bit count, high byte plus low five.
// - Wrap from all ones sets overflow flag.
// - Counter select counts falling edges on pin.
// - Timer select: system clock or prescaled tick.
// - Counts when run and (no gate or gate active).
// - First gate polarity from configuration bit.
// - Run bit starts from present count, no reload.
// - Second timer identical, own polarity bit.
// - Overflow interrupt forwarded only when enabled.
// - High bytes read/write, reset zero, fixed addresses.
`ifndef DCTM_REGS_VH
`define DCTM_REGS_VH

`define DCTM_ADDR_CTRL    8'h88
`define DCTM_ADDR_MODE    8'h89
`define DCTM_ADDR_LOW0    8'h8a
`define DCTM_ADDR_LOW1    8'h8b
`define DCTM_ADDR_HIGH0   8'h8c
`define DCTM_ADDR_HIGH1   8'h8d
`define DCTM_ADDR_SCALE   8'h8e
`define DCTM_ADDR_IRQCFG  8'he4
`define DCTM_ADDR_IRQEN   8'ha8
`define DCTM_ADDR_STATUS  8'h90
`define DCTM_ADDR_MASK    8'h91

// Control register fields.
`define DCTM_CTRL_OVF0    5
`define DCTM_CTRL_RUN0    4
`define DCTM_CTRL_OVF1    7
`define DCTM_CTRL_RUN1    6
// Mode register fields: timer 0 low nibble, timer 1 high nibble.
`define DCTM_MODE_GATE    3
`define DCTM_MODE_CT      2
// Scale register fields.
`define DCTM_SCALE_SYS0   2
`define DCTM_SCALE_SYS1   3
// Interrupt configuration and enable fields.
`define DCTM_CFG_POL0     3
`define DCTM_CFG_POL1     7
`define DCTM_EN_IRQ0      1
`define DCTM_EN_IRQ1      3

`define DCTM_RESET_BYTE   8'h00

// Prescaled tick periods in system clocks, selected by scale bits 1:0.
`define DCTM_DIV_12       8'd12
`define DCTM_DIV_4        8'd4
`define DCTM_DIV_48       8'd48
`define DCTM_DIV_8        8'd8

`endif

/* core/dctm_channel.v */
// One 13-bit mode 0 counter/timer channel with its own edge detection.
`include "dctm_regs.vh"

module dctm_channel (
	input  wire       sys_clk,
	input  wire       rstn,
	input  wire       countPin,
	input  wire       gatePin,
	input  wire       gatePolarity,
	input  wire       runBit,
	input  wire       gateBit,
	input  wire       counterSelect,
	input  wire       sysclkSelect,
	input  wire       scaleTick,
	input  wire       lowWrite,
	input  wire       highWrite,
	input  wire [7:0] writeData,
	output wire [7:0] lowByte,
	output wire [7:0] highByte,
	output wire       overflowPulse
);

	reg  [2:0]  pinSync_reg;
	reg  [2:0]  gateSync_reg;
	reg         pinState_reg;
	reg         gateState_reg;
	reg  [12:0] count_reg;
	reg  [12:0] count_next;
	reg         ovf_reg;
	reg         ovf_next;
	wire        fallEdge;
	wire        enabled;
	wire        tick;

	// A stable value needs the second and third stages to agree.
	always @(posedge sys_clk) begin
		if (!rstn) begin
			pinSync_reg   <= 3'h7;
			gateSync_reg  <= 3'h0;
			pinState_reg  <= 1'b1;
			gateState_reg <= 1'b0;
		end else begin
			pinSync_reg  <= {pinSync_reg[1:0], countPin};
			gateSync_reg <= {gateSync_reg[1:0], gatePin};
			if (pinSync_reg[1] == pinSync_reg[2])
				pinState_reg <= pinSync_reg[2];
			if (gateSync_reg[1] == gateSync_reg[2])
				gateState_reg <= gateSync_reg[2];
		end
	end

	// One increment per falling edge of the settled pin level.
	assign fallEdge = pinState_reg & (pinSync_reg[1] == pinSync_reg[2]) &
	                  ~pinSync_reg[2];
	assign enabled = runBit &
	                 (~gateBit | (gateState_reg == gatePolarity));
	assign tick = counterSelect ? fallEdge :
	              (sysclkSelect ? 1'b1 : scaleTick);

	always @* begin
		count_next = count_reg;
		ovf_next   = 1'b0;
		// Run only gates counting; the count is never cleared here.
		if (enabled && tick) begin
			count_next = count_reg + 13'h0001;
			ovf_next   = (count_reg == 13'h1fff);
		end
		// A software write wins over a coincident increment only in the bits it writes; the overflow pulse still fires.
		if (lowWrite)
			count_next[4:0] = writeData[4:0];
		if (highWrite)
			count_next[12:5] = writeData;
	end

	always @(posedge sys_clk) begin
		if (!rstn) begin
			count_reg <= 13'h0000;
			ovf_reg   <= 1'b0;
		end else begin
			count_reg <= count_next;
			ovf_reg   <= ovf_next;
		end
	end

	// Upper three low-byte bits read as zero.
	assign lowByte       = {3'h0, count_reg[4:0]};
	assign highByte      = count_reg[12:5];
	assign overflowPulse = ovf_reg;

endmodule

/* verif/dctm_chk.sv */
// Assertions on the counter/timer register port and interrupt outputs.
module dctm_chk (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regRdata,
	input wire logic       firstTimerIrq,
	input wire logic       secondTimerIrq,
	input wire logic       irqOut
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       en0_reg;
	logic       en1_reg;
	logic [1:0] mask_reg;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Shadow copies of the enable and mask bits as software wrote them.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			en0_reg <= 1'b0;
			en1_reg <= 1'b0;
			mask_reg <= 2'b00;
		end else begin
			if (regWrite && regAddr == 8'ha8) begin
				en0_reg <= regWdata[1];
				en1_reg <= regWdata[3];
			end
			if (regWrite && regAddr == 8'h91)
				mask_reg <= regWdata[1:0];
		end
	end
	low_upper_zero_a:
	assert property (regRead && (regAddr == 8'h8a || regAddr == 8'h8b)
		|=> regRdata[7:5] == 3'b000) else $error("low byte top bits set");
	unmapped_read_a:
	assert property (regRead && regAddr == 8'h00 |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	idle_read_a:
	assert property (!regRead |=> regRdata == 8'h00)
		else $error("read data outside its slot");
	status_bits_a:
	assert property (regRead && regAddr == 8'h90 |=> regRdata[7:2] == 6'h00)
		else $error("status spare bits set");
	first_irq_gate_a:
	assert property (!en0_reg |=> !firstTimerIrq)
		else $error("first irq while disabled");
	second_irq_gate_a:
	assert property (!en1_reg |=> !secondTimerIrq)
		else $error("second irq while disabled");
	irq_mask_a:
	assert property (mask_reg == 2'b00 |=> !irqOut)
		else $error("irq out while all masked");
	reset_quiet_a:
	assert property ($rose(rstn) |-> !irqOut && !firstTimerIrq && !secondTimerIrq)
		else $error("irq high after reset");
endmodule

bind dctm_top dctm_chk dctm_chk_i (.sys_clk, .rstn, .regAddr, .regWdata,
	.regWrite, .regRead, .regRdata, .firstTimerIrq, .secondTimerIrq, .irqOut);

/* verif/testbench.sv */
// Self-checking bench for the dual counter/timer.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk, rstn, regWrite, regRead, pin0, pin1, first_gate_bit, gate1;
	logic [7:0] regAddr, regWdata, rdVal;
	wire  [7:0] regRdata;
	wire        irq0, irq1, irqOut;
	int         n_mismatch = 0, n_compared = 0, seed = 87545, k, n, v;
	dctm_top dctm_top_i (.sys_clk, .rstn, .regAddr, .regWdata, .regWrite,
		.regRead, .regRdata, .firstCountInputPin(pin0),
		.secondCountInputPin(pin1), .firstGateInput(first_gate_bit),
		.secondGateInput(gate1), .firstTimerIrq(irq0),
		.secondTimerIrq(irq1), .irqOut);
	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk);
	endtask
	// A spare cycle follows each strobe so no signal is driven twice at one edge.
	task automatic wr(input logic [7:0] a, d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 rdVal = regRdata;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdChk(input logic [7:0] a, exp);
		rd(a);
		chk(rdVal, exp);
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		cyc(5000);
		n_mismatch++;
		end_of_test;
	end
	initial begin
		{regWrite, regRead, first_gate_bit, gate1, pin0, pin1} <= 6'b000011;
		{regAddr, regWdata, rstn} <= 17'h0;
		cyc(6);
		rstn <= 1'b1;
		cyc(4);
		rdChk(8'h8c, 8'h00);
		rdChk(8'h8d, 8'h00);
		v = $random(seed);
		wr(8'h8c, v[7:0]);
		wr(8'h8d, ~v[7:0]);
		rdChk(8'h8c, v[7:0]);
		rdChk(8'h8d, ~v[7:0]);
		wr(8'h00, 8'hff);
		rdChk(8'h00, 8'h00);
		$display("test registers done");
		wr(8'ha8, 8'h02);
		wr(8'h91, 8'h01);
		wr(8'h8e, 8'h04);
		wr(8'h8c, 8'hff);
		wr(8'h8a, 8'hff);
		rdChk(8'h8a, 8'h1f);
		wr(8'h88, 8'h10);
		cyc(2);
		rdChk(8'h88, 8'h30);
		rdChk(8'h90, 8'h01);
		chk({irq0, irqOut}, 8'h03);
		wr(8'ha8, 8'h00);
		cyc(2);
		chk({irq0, irqOut}, 8'h01);
		wr(8'h90, 8'h01);
		cyc(2);
		chk(irqOut, 8'h00);
		wr(8'h88, 8'h00);
		rdChk(8'h88, 8'h00);
		$display("test overflow done");
		wr(8'h89, 8'h08);
		wr(8'he4, 8'h08);
		wr(8'h8c, 8'h09);
		wr(8'h8a, 8'h00);
		wr(8'h88, 8'h10);
		cyc(10);
		rdChk(8'h8a, 8'h00);
		@(posedge sys_clk) first_gate_bit <= 1'b1;
		cyc(20);
		@(posedge sys_clk) first_gate_bit <= 1'b0;
		cyc(5);
		rd(8'h8a);
		v = rdVal & 8'h1f;
		chk(v > 11 && v < 32, 8'h01);
		wr(8'he4, 8'h00);
		cyc(5);
		rd(8'h8a);
		chk((rdVal & 8'h1f) > v, 8'h01);
		wr(8'h88, 8'h00);
		rdChk(8'h8c, 8'h09);
		$display("test gate done");
		wr(8'h89, 8'h40);
		wr(8'h8b, 8'h00);
		wr(8'h8d, 8'h00);
		wr(8'h88, 8'h40);
		n = ($random(seed) & 7) + 1;
		for (k = 0; k < n; k++) begin
			@(posedge sys_clk) pin1 <= 1'b0;
			cyc(4);
			@(posedge sys_clk) pin1 <= 1'b1;
			cyc(4);
		end
		cyc(6);
		wr(8'h88, 8'h00);
		rdChk(8'h8b, n[7:0]);
		rdChk(8'h8d, 8'h00);
		$display("test pin count done");
		wr(8'h89, 8'h00);
		wr(8'h8e, 8'h08);
		wr(8'ha8, 8'h08);
		wr(8'h91, 8'h02);
		wr(8'h8d, 8'hff);
		wr(8'h8b, 8'hff);
		wr(8'h88, 8'h40);
		cyc(2);
		rdChk(8'h88, 8'hc0);
		rdChk(8'h90, 8'h02);
		chk({irq1, irqOut}, 8'h03);
		wr(8'h88, 8'h00);
		wr(8'h90, 8'h02);
		wr(8'h91, 8'h00);
		cyc(2);
		chk({irq1, irqOut}, 8'h00);
		$display("test second overflow done");
		wr(8'h89, 8'h00);
		wr(8'h8e, 8'h01);
		wr(8'h8a, 8'h00);
		wr(8'h8c, 8'h00);
		wr(8'h88, 8'h10);
		cyc(40);
		wr(8'h88, 8'h00);
		rd(8'h8a);
		chk(rdVal >= 9 && rdVal <= 13, 8'h01);
		$display("test prescale done");
		end_of_test;
	end
endmodule
